// file: rtl/ortr_ramp_gen.sv
`timescale 1ns/100ps
`include "ortr_consts.svh"

module ortr_ramp_gen
(
    input wire logic mclk,
    input wire logic reset,
    ortr_ramp_if.gen rp
);
    import ortr_pkg::*;

    localparam int PRE_W = $clog2(`ORTR_CYC_PER_US);

    ortr_state_t state_r, state_nxt;
    logic [31:0] totalUs_r, totalUs_nxt;
    logic [31:0] elapsed_r, elapsed_nxt;
    logic [31:0] step_r, step_nxt;
    logic [32:0] acc_r, acc_nxt;
    logic [32:0] rem_r, rem_nxt;
    logic [5:0] bitCnt_r, bitCnt_nxt;
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [15:0] level_r, level_nxt;
    logic signed [4:0] expo;
    logic signed [10:0] mant;
    logic [35:0] scaled;
    logic [35:0] prod;
    logic [32:0] trial;
    logic go;
    logic tick;

    // ----------------------------------------
    // Linear word to microseconds
    // ----------------------------------------
    always_comb
    begin
        expo = rp.riseWord[`ORTR_EXP_MSB:`ORTR_EXP_LSB];
        mant = rp.riseWord[`ORTR_MANT_MSB:`ORTR_MANT_LSB];
        prod = 36'h0;
        // A negative mantissa is meaningless as a time and ramps in zero time.
        if (!mant[10])
        begin
            prod = 36'(mant) * 36'(`ORTR_US_PER_MS);
        end
        if (expo >= 0)
        begin
            scaled = prod << expo;
        end
        else
        begin
            scaled = prod >> (-expo);
        end
    end

    assign go = rp.enable && rp.startOk;
    assign tick = (pre_r == PRE_W'(`ORTR_CYC_PER_US - 1));

    // ----------------------------------------
    // Ramp sequencer
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        totalUs_nxt = totalUs_r;
        elapsed_nxt = elapsed_r;
        step_nxt = step_r;
        acc_nxt = acc_r;
        rem_nxt = rem_r;
        bitCnt_nxt = bitCnt_r;
        pre_nxt = pre_r;
        level_nxt = level_r;
        trial = {rem_r[31:0], 1'b1} - {1'b0, totalUs_r};
        case (state_r)
            ORTR_IDLE:
            begin
                level_nxt = 16'h0000;
                if (go)
                begin
                    // The setting is captured here so a write mid-ramp cannot bend the slope.
                    totalUs_nxt = (|scaled[35:32]) ? 32'hffffffff : scaled[31:0];
                    rem_nxt = 33'h0;
                    step_nxt = 32'h0;
                    bitCnt_nxt = 6'h00;
                    state_nxt = ORTR_CALC;
                end
            end
            ORTR_CALC:
            begin
                // Serial divide of all-ones by the rise time gives the per-microsecond step.
                if (totalUs_r == 32'h0)
                begin
                    level_nxt = 16'hffff;
                    state_nxt = ORTR_DONE;
                end
                else if (bitCnt_r == 6'd32)
                begin
                    acc_nxt = 33'h0;
                    elapsed_nxt = 32'h0;
                    pre_nxt = '0;
                    state_nxt = ORTR_RAMP;
                end
                else
                begin
                    bitCnt_nxt = bitCnt_r + 6'h01;
                    if (!trial[32])
                    begin
                        rem_nxt = trial;
                        step_nxt = {step_r[30:0], 1'b1};
                    end
                    else
                    begin
                        rem_nxt = {rem_r[31:0], 1'b1};
                        step_nxt = {step_r[30:0], 1'b0};
                    end
                end
            end
            ORTR_RAMP:
            begin
                pre_nxt = tick ? '0 : pre_r + PRE_W'(1);
                if (tick)
                begin
                    elapsed_nxt = elapsed_r + 32'h1;
                    acc_nxt = acc_r + {1'b0, step_r};
                    level_nxt = acc_nxt[31:16];
                    if (elapsed_nxt >= totalUs_r || acc_nxt[32])
                    begin
                        level_nxt = 16'hffff;
                        state_nxt = ORTR_DONE;
                    end
                end
            end
            ORTR_DONE:
            begin
                level_nxt = 16'hffff;
            end
            default:
            begin
                state_nxt = ORTR_IDLE;
            end
        endcase
        if (!rp.enable && state_r != ORTR_IDLE)
        begin
            level_nxt = 16'h0000;
            state_nxt = ORTR_IDLE;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_r <= ORTR_IDLE;
            totalUs_r <= 32'h0;
            elapsed_r <= 32'h0;
            step_r <= 32'h0;
            acc_r <= 33'h0;
            rem_r <= 33'h0;
            bitCnt_r <= 6'h00;
            pre_r <= '0;
            level_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            totalUs_r <= totalUs_nxt;
            elapsed_r <= elapsed_nxt;
            step_r <= step_nxt;
            acc_r <= acc_nxt;
            rem_r <= rem_nxt;
            bitCnt_r <= bitCnt_nxt;
            pre_r <= pre_nxt;
            level_r <= level_nxt;
        end
    end

    assign rp.level = level_r;
    assign rp.busy = (state_r == ORTR_CALC) || (state_r == ORTR_RAMP);
    assign rp.done = (state_r == ORTR_DONE);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_no_early_start;
        @(posedge mclk) disable iff (reset)
        (state_r == ORTR_IDLE && !go) |=> (state_r == ORTR_IDLE && level_r == 16'h0000);
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("Ramp left idle without enable and wait done.");

    property p_ramp_end;
        @(posedge mclk) disable iff (reset)
        (state_r == ORTR_RAMP && tick && rp.enable && elapsed_r + 32'h1 == totalUs_r) |=> (rp.done && level_r == 16'hffff);
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("Ramp did not finish at the programmed time.");

    property p_decode_default;
        @(posedge mclk) disable iff (reset)
        (state_r == ORTR_IDLE && go && rp.riseWord == 16'hca80) |=> (totalUs_r == 32'd5000);
    endproperty
    a_decode_default: assert property (p_decode_default) else $error("Default word did not decode to 5000 us.");

    c_ramp_done: cover property (@(posedge mclk) disable iff (reset) state_r == ORTR_RAMP ##1 state_r == ORTR_DONE);
    c_abort: cover property (@(posedge mclk) disable iff (reset) state_r == ORTR_RAMP ##1 state_r == ORTR_IDLE);
endmodule

// file: rtl/ortr_consts.svh
`ifndef ORTR_CONSTS_SVH
`define ORTR_CONSTS_SVH

// ----------------------------------------
// Command code and register layout
// ----------------------------------------
`define ORTR_CMD_RISE 8'h61
`define ORTR_RISE_RESET 16'hca80
`define ORTR_EXP_MSB 15
`define ORTR_EXP_LSB 11
`define ORTR_MANT_MSB 10
`define ORTR_MANT_LSB 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ORTR_CLK_PERIOD_NS 4
`define ORTR_US_NS 1000
`define ORTR_CYC_PER_US (`ORTR_US_NS / `ORTR_CLK_PERIOD_NS)
`define ORTR_US_PER_MS 1000

`endif

// file: rtl/ortr_pkg.sv
package ortr_pkg;

    typedef logic [15:0] ortr_word_t;

    typedef enum logic [1:0]
    {
        ORTR_IDLE = 2'b00,
        ORTR_CALC = 2'b01,
        ORTR_RAMP = 2'b11,
        ORTR_DONE = 2'b10
    } ortr_state_t;

endpackage

// file: rtl/ortr_ramp_if.sv
`timescale 1ns/100ps

interface ortr_ramp_if;
    logic [15:0] riseWord;
    logic enable;
    logic startOk;
    logic [15:0] level;
    logic busy;
    logic done;

    modport gen
    (
        input riseWord,
        input enable,
        input startOk,
        output level,
        output busy,
        output done
    );

    modport ctrl
    (
        output riseWord,
        output enable,
        output startOk,
        input level,
        input busy,
        input done
    );
endinterface

// file: rtl/ortr_top.sv
`timescale 1ns/100ps
`include "ortr_consts.svh"

// Behaviour
// - Each output ramps from zero to full over its rise time, starting only once enabled and the turn-on wait is over.
// - Every page has its own rise-time setting and a command touches only the selected page.
// - The setting travels as one 16-bit word in the signed exponent and mantissa format, in both directions.
// - The host may read and write the setting, but a write is refused while write protection is on.
// - After reset every setting holds ca80, which is 5 ms, and the unit is always milliseconds.
module ortr_top
#(
    parameter int NUM_PAGES = 2,
    parameter int PAGE_W = 1
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [PAGE_W-1:0] cmdPage,
    input wire ortr_pkg::ortr_word_t cmdWrData,
    input wire logic writeProtect,
    input wire logic [NUM_PAGES-1:0] enablePin,
    input wire logic [NUM_PAGES-1:0] turnOnWaitDone,
    output logic cmdAck,
    output logic cmdRefused,
    output ortr_pkg::ortr_word_t cmdRdData,
    output logic [NUM_PAGES*16-1:0] regulatedOutputVoltage,
    output logic [NUM_PAGES-1:0] rampBusy,
    output logic [NUM_PAGES-1:0] rampDone
);
    import ortr_pkg::*;

    if (NUM_PAGES < 1 || NUM_PAGES > (1 << PAGE_W))
    begin : g_bad_pages
        $error("NUM_PAGES does not fit the page select width.");
    end

    ortr_word_t riseSet_r [NUM_PAGES];
    ortr_word_t riseSet_nxt [NUM_PAGES];
    ortr_word_t rdData_r, rdData_nxt;
    logic ack_r, ack_nxt;
    logic refused_r, refused_nxt;
    logic [NUM_PAGES-1:0] sync1_r, sync2_r, sync3_r, enLvl_r, enLvl_nxt;
    logic hit;
    logic pageOk;

    // ----------------------------------------
    // Enable pin synchronisers
    // ----------------------------------------
    always_comb
    begin
        // A change is taken only when the last two stages agree, which also rejects single glitches.
        for (int i = 0; i < NUM_PAGES; i++)
        begin
            enLvl_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : enLvl_r[i];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            enLvl_r <= '0;
        end
        else
        begin
            sync1_r <= enablePin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            enLvl_r <= enLvl_nxt;
        end
    end

    // ----------------------------------------
    // Rise-time setting per page
    // ----------------------------------------
    assign hit = cmdValid && (cmdCode == `ORTR_CMD_RISE);
    assign pageOk = (32'(cmdPage) < NUM_PAGES);

    always_comb
    begin
        riseSet_nxt = riseSet_r;
        rdData_nxt = rdData_r;
        ack_nxt = 1'b0;
        refused_nxt = 1'b0;
        if (hit)
        begin
            if (!pageOk || (cmdWrite && writeProtect))
            begin
                refused_nxt = 1'b1;
            end
            else
            begin
                ack_nxt = 1'b1;
                if (cmdWrite)
                begin
                    riseSet_nxt[cmdPage] = cmdWrData;
                end
                else
                begin
                    rdData_nxt = riseSet_r[cmdPage];
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_PAGES; i++)
            begin
                riseSet_r[i] <= `ORTR_RISE_RESET;
            end
            rdData_r <= 16'h0000;
            ack_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            riseSet_r <= riseSet_nxt;
            rdData_r <= rdData_nxt;
            ack_r <= ack_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign cmdAck = ack_r;
    assign cmdRefused = refused_r;
    assign cmdRdData = rdData_r;

    // ----------------------------------------
    // Ramp generators
    // ----------------------------------------
    for (genvar p = 0; p < NUM_PAGES; p++)
    begin : g_page
        ortr_ramp_if rif();

        assign rif.riseWord = riseSet_r[p];
        assign rif.enable = enLvl_r[p];
        assign rif.startOk = turnOnWaitDone[p];
        assign regulatedOutputVoltage[p*16 +: 16] = rif.level;
        assign rampBusy[p] = rif.busy;
        assign rampDone[p] = rif.done;

        ortr_ramp_gen u_gen
        (
            .mclk(mclk),
            .reset(reset),
            .rp(rif.gen)
        );
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_reset_value;
        @(posedge mclk) disable iff (reset)
        $past(reset) |-> (riseSet_r[0] == 16'hca80 && riseSet_r[NUM_PAGES-1] == 16'hca80);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("Setting not at ca80 after reset.");

    property p_protect;
        @(posedge mclk) disable iff (reset)
        (hit && cmdWrite && writeProtect) |=> (cmdRefused && !cmdAck && $stable(riseSet_r[0]));
    endproperty
    a_protect: assert property (p_protect) else $error("Protected write was not refused.");

    property p_write_page0;
        @(posedge mclk) disable iff (reset)
        (hit && cmdWrite && !writeProtect && cmdPage == '0) |=>
            (cmdAck && riseSet_r[0] == $past(cmdWrData) && $stable(riseSet_r[NUM_PAGES-1]) || NUM_PAGES == 1);
    endproperty
    a_write_page0: assert property (p_write_page0) else $error("Write did not land on the selected page only.");

    property p_read_back;
        @(posedge mclk) disable iff (reset)
        (hit && !cmdWrite && pageOk) |=> (cmdAck && cmdRdData == riseSet_r[$past(cmdPage)]);
    endproperty
    a_read_back: assert property (p_read_back) else $error("Read word differs from the page setting.");

    c_refused: cover property (@(posedge mclk) disable iff (reset) cmdRefused);
    c_read: cover property (@(posedge mclk) disable iff (reset) (hit && !cmdWrite) ##1 cmdAck);
endmodule

// file: tb/ortr_bus_host.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host side of the command port
// ----------------------------------------
module ortr_bus_host
(
    input wire logic mclk,
    input wire logic cmdAck,
    input wire logic cmdRefused,
    input wire ortr_pkg::ortr_word_t cmdRdData,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [0:0] cmdPage,
    output ortr_pkg::ortr_word_t cmdWrData
);
    import ortr_pkg::*;

    initial
    begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdPage = 1'b0;
        cmdWrData = 16'h0000;
    end

    // One whole 16-bit word per command, never split into bytes.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [0:0] page, input ortr_word_t data,
                        output logic ack, output logic refused, output ortr_word_t rd);
        int n;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdCode <= code;
        cmdPage <= page;
        cmdWrData <= data;
        @(posedge mclk);
        cmdValid <= 1'b0;
        // A released bus must not keep showing the old word.
        cmdWrData <= ~data;
        cmdCode <= ~code;
        // The answer stands for one cycle only, so it is sampled mid-cycle to stay clear of the launching edge.
        for (n = 0; n < 3; n++)
        begin
            @(negedge mclk);
            if (cmdAck === 1'b1 || cmdRefused === 1'b1)
                break;
        end
        ack = cmdAck;
        refused = cmdRefused;
        rd = cmdRdData;
    endtask
endmodule

// file: tb/output_rise_time_ramp_tb.sv
`timescale 1ns/100ps

module output_rise_time_ramp_tb;
    import ortr_pkg::*;

    logic mclk;
    logic reset;
    logic cmdValid;
    logic cmdWrite;
    logic [7:0] cmdCode;
    logic [0:0] cmdPage;
    ortr_word_t cmdWrData;
    logic writeProtect;
    logic [1:0] enablePin;
    logic [1:0] turnOnWaitDone;
    logic cmdAck;
    logic cmdRefused;
    ortr_word_t cmdRdData;
    logic [31:0] regulatedOutputVoltage;
    logic [1:0] rampBusy;
    logic [1:0] rampDone;
    int error_cnt;
    int num_checks;

    ortr_top uut
    (
        .mclk(mclk), .reset(reset), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdPage(cmdPage), .cmdWrData(cmdWrData), .writeProtect(writeProtect), .enablePin(enablePin),
        .turnOnWaitDone(turnOnWaitDone), .cmdAck(cmdAck), .cmdRefused(cmdRefused), .cmdRdData(cmdRdData),
        .regulatedOutputVoltage(regulatedOutputVoltage), .rampBusy(rampBusy), .rampDone(rampDone)
    );

    ortr_bus_host host
    (
        .mclk(mclk), .cmdAck(cmdAck), .cmdRefused(cmdRefused), .cmdRdData(cmdRdData), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk16(input string name, input ortr_word_t expv, input ortr_word_t got);
        num_checks++;
        if (got !== expv)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, expv, got);
        end
    endtask

    task automatic chk1(input string name, input logic expv, input logic got);
        num_checks++;
        if (got !== expv)
        begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", name, expv, got);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Read data is judged only on an accepted read.
    task automatic access(input string name, input logic wr, input logic [7:0] code, input logic [0:0] pg,
                          input ortr_word_t data, input logic expAck, input logic expRef, input ortr_word_t expRd);
        logic ack;
        logic refused;
        ortr_word_t rd;
        host.xfer(wr, code, pg, data, ack, refused, rd);
        chk1({name, "Ack"}, expAck, ack);
        chk1({name, "Refused"}, expRef, refused);
        if (!wr && expAck)
            chk16({name, "Data"}, expRd, rd);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_values();
        access("readPage0", 1'b0, 8'h61, 1'b0, 16'h0000, 1'b1, 1'b0, 16'hca80);
        access("readPage1", 1'b0, 8'h61, 1'b1, 16'h0000, 1'b1, 1'b0, 16'hca80);
        access("otherCode", 1'b0, 8'h64, 1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000);
        $display("test_reset_values done");
    endtask

    task automatic test_paged_access();
        access("writePage0", 1'b1, 8'h61, 1'b0, 16'h5a5a, 1'b1, 1'b0, 16'h0000);
        access("readBack0", 1'b0, 8'h61, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h5a5a);
        access("untouched1", 1'b0, 8'h61, 1'b1, 16'h0000, 1'b1, 1'b0, 16'hca80);
        $display("test_paged_access done");
    endtask

    task automatic test_protect();
        @(posedge mclk);
        writeProtect <= 1'b1;
        access("protWrite", 1'b1, 8'h61, 1'b0, 16'h1234, 1'b0, 1'b1, 16'h0000);
        access("protRead", 1'b0, 8'h61, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h5a5a);
        @(posedge mclk);
        writeProtect <= 1'b0;
        $display("test_protect done");
    endtask

    // Time from the turn-on wait ending to full level must match the word.
    task automatic test_ramp(input logic [0:0] pg, input ortr_word_t word, input int expCyc);
        int n;
        access("rampWrite", 1'b1, 8'h61, pg, word, 1'b1, 1'b0, 16'h0000);
        @(posedge mclk);
        enablePin[pg] <= 1'b1;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        chk1("busyBeforeWait", 1'b0, rampBusy[pg]);
        chk16("levelBeforeWait", 16'h0000, regulatedOutputVoltage[pg*16+:16]);
        @(posedge mclk);
        turnOnWaitDone[pg] <= 1'b1;
        for (n = 0; n < 40000 && rampDone[pg] !== 1'b1; n++)
            @(negedge mclk);
        if (n >= 40000)
        begin
            error_cnt++;
            $display("[ERR] rampDone expected 1 seen timeout");
            finish_test();
        end
        chk1("doneInWindow", 1'b1, n >= expCyc && n <= expCyc + 80);
        chk16("levelFull", 16'hffff, regulatedOutputVoltage[pg*16+:16]);
        @(posedge mclk);
        enablePin[pg] <= 1'b0;
        turnOnWaitDone[pg] <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk1("doneAfterOff", 1'b0, rampDone[pg]);
        chk16("levelAfterOff", 16'h0000, regulatedOutputVoltage[pg*16+:16]);
        $display("test_ramp done");
    endtask

    // Page 1 still holds the reset word here; a full 5 ms ramp is too long, so it is cut short by enable.
    task automatic test_abort();
        @(posedge mclk);
        enablePin[1] <= 1'b1;
        turnOnWaitDone[1] <= 1'b1;
        repeat (800) @(posedge mclk);
        @(negedge mclk);
        chk1("busyMidRamp", 1'b1, rampBusy[1]);
        chk1("levelRising", 1'b1, regulatedOutputVoltage[31:16] != 16'h0000 && regulatedOutputVoltage[31:16] != 16'hffff);
        chk1("doneMidRamp", 1'b0, rampDone[1]);
        @(posedge mclk);
        enablePin[1] <= 1'b0;
        turnOnWaitDone[1] <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk1("busyAfterAbort", 1'b0, rampBusy[1]);
        chk16("levelAfterAbort", 16'h0000, regulatedOutputVoltage[31:16]);
        $display("test_abort done");
    endtask

    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        reset = 1'b1;
        writeProtect = 1'b0;
        enablePin = 2'b00;
        turnOnWaitDone = 2'b00;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        test_reset_values();
        test_paged_access();
        test_protect();
        test_ramp(1'b0, 16'he801, 125 * 250);
        test_abort();
        test_ramp(1'b1, 16'hd803, 93 * 250);
        test_ramp(1'b0, 16'h0000, 0);
        finish_test();
    end
endmodule
